/* File: mac_round_pkg.sv */
// constants, modes and mode decode for the multiply-accumulate rounding block
package mac_round_pkg;

  localparam int STATUS_W = 8;
  localparam int SU_BIT = 6;
  localparam int FI_BIT = 5;
  localparam int RT_BIT = 4;
  localparam int MASK_EXT_BIT = 5;

  localparam logic [STATUS_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [15:0] MASK_UPPER = 16'hFFFF;

  localparam int PROD_W = 64;
  localparam int PROD_OUT_W = 40;
  localparam int PROD_KEEP_LSB = 24;
  localparam int ACC_W = 48;
  localparam int ACC_FRAC_MSB = 39;
  localparam int ACC_FRAC32_LSB = 8;

  localparam logic [5:0] PROD_DROP = 6'h18;
  localparam logic [5:0] STORE_DROP32 = 6'h08;
  localparam logic [5:0] STORE_DROP16 = 6'h18;
  localparam logic [23:0] PROD_HALF = 24'h800000;

  localparam logic [1:0] SF_LEFT = 2'h1;
  localparam logic [1:0] SF_RIGHT = 2'h3;

  typedef enum logic [2:0] {
    MODE_SIGNED_INT = 3'b000,
    MODE_UNSIGNED_INT = 3'b001,
    MODE_FRAC_TRUNC = 3'b010,
    MODE_FRAC_ROUND32 = 3'b011,
    MODE_FRAC_R16_TRUNC = 3'b100,
    MODE_FRAC_R16_ROUND = 3'b101
  } mode_t;

  function automatic mode_t decode_mode(input logic [STATUS_W-1:0] status);
    mode_t m;
    m = MODE_SIGNED_INT;
    case ({status[SU_BIT], status[FI_BIT], status[RT_BIT]})
      3'b000, 3'b001: m = MODE_SIGNED_INT;
      3'b010: m = MODE_FRAC_TRUNC;
      3'b011: m = MODE_FRAC_ROUND32;
      3'b100, 3'b101: m = MODE_UNSIGNED_INT;
      3'b110: m = MODE_FRAC_R16_TRUNC;
      3'b111: m = MODE_FRAC_R16_ROUND;
      default: m = MODE_SIGNED_INT;
    endcase
    return m;
  endfunction

endpackage

/* File: round_if.sv */
// carrier between the block and its convergent rounder
`timescale 1ns/10ps
interface round_if;
  logic [63:0] val;
  logic [5:0] drop;
  logic [63:0] res;
  modport req(output val, output drop, input res);
  modport unit(input val, input drop, output res);
endinterface

/* File: round_even.sv */
// convergent (round half to even) rounder, drop of at least one bit
`timescale 1ns/10ps
module round_even (
  round_if.unit rif
);
  logic [63:0] half;
  logic [63:0] low;
  logic [63:0] kept;
  logic up;

  always_comb begin
    half = 64'h1 << (rif.drop - 6'h01);
    low = rif.val & ((64'h1 << rif.drop) - 64'h1);
    kept = rif.val >> rif.drop;
    // tie goes to whichever neighbour is even
    up = (low > half) || ((low == half) && kept[0]);
    rif.res = kept + {63'h0, up};
  end
endmodule

/* File: mac_round_unit.sv */
// mode control, convergent rounding and operand address mask of the mac unit
//
// Function
// [RULE1] integer mode when fraction bit clear; signedness picks signed or unsigned
// [RULE2] signed fraction: round bit chooses truncate/no-round or round, 32-bit stores
// [RULE3] fraction with signedness set: stores round to 16 bits using low 24
// [RULE4] fraction, signedness clear, rounding on: store rounds 32 bits using low 8
// [RULE5] long fractional product truncated to top 40 bits, or rounded to even
// [RULE6] below half keeps upper part, above half increments it
// [RULE7] exactly half rounds so the kept lsb ends even
// [RULE8] rounding only in fraction mode, on stores and long mac products
// [RULE9] software clears status before save or restore for bit-exact access
// [RULE10] save and restore order: status, accumulators, extensions, mask, status last
// [RULE11] plain multiplies always treat operands as integers
// [RULE12] scale factor ignored while fraction mode is set
// [RULE13] mask load keeps only low 16 bits of the operand
// [RULE14] mask read returns stored low half with upper 16 bits all ones
// [RULE15] masked address is address ANDed with ones over mask
// [RULE16] masking per instruction via extension word bit 5 on mac-with-load
// [RULE17] long product exact-half tie rounds top 40 bits to even
`timescale 1ns/10ps
module mac_round_unit (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_status_wr,
  input wire logic [7:0] i_status_wdata,
  input wire logic i_mask_wr,
  input wire logic [31:0] i_mask_wdata,
  input wire logic i_prod_valid,
  input wire logic i_prod_long,
  input wire logic [1:0] i_prod_sf,
  input wire logic [63:0] i_prod,
  input wire logic i_store_valid,
  input wire logic [47:0] i_acc,
  input wire logic i_mul_valid,
  input wire logic i_mul_signed,
  input wire logic [15:0] i_mul_a,
  input wire logic [15:0] i_mul_b,
  input wire logic i_addr_valid,
  input wire logic [31:0] i_addr,
  input wire logic [15:0] i_ext_word,
  output logic [7:0] o_status_rdata,
  output logic [31:0] o_mask_rdata,
  output logic o_prod_valid,
  output logic [39:0] o_prod,
  output logic o_store_valid,
  output logic [31:0] o_store_data,
  output logic o_mul_valid,
  output logic [31:0] o_mul_result,
  output logic o_addr_valid,
  output logic [31:0] o_addr
);

  typedef struct packed {
    logic [7:0] status;
    logic [15:0] mask;
    logic [31:0] mask_rd;
    logic prod_valid;
    logic [39:0] prod;
    logic store_valid;
    logic [31:0] store;
    logic mul_valid;
    logic [31:0] mul;
    logic addr_valid;
    logic [31:0] addr;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  mac_round_pkg::mode_t mode;
  logic frac;
  logic round_sel;
  logic [63:0] scaled;
  logic signed [31:0] smul;
  logic [31:0] umul;

  round_if prif ();
  round_if srif ();

  round_even u_prod_round (
    .rif(prif)
  );

  round_even u_store_round (
    .rif(srif)
  );

  assign prif.val = i_prod;
  assign prif.drop = mac_round_pkg::PROD_DROP;
  assign srif.val = {16'h0000, i_acc};
  // 24 dropped bits for the 16-bit result, 8 for the 32-bit one
  assign srif.drop = st_r.status[mac_round_pkg::SU_BIT] ? mac_round_pkg::STORE_DROP16 :
                     mac_round_pkg::STORE_DROP32;
  assign smul = $signed(i_mul_a) * $signed(i_mul_b);
  assign umul = i_mul_a * i_mul_b;

  always_comb begin
    st_nxt = st_r;
    mode = mac_round_pkg::decode_mode(st_r.status);
    frac = st_r.status[mac_round_pkg::FI_BIT];
    round_sel = st_r.status[mac_round_pkg::RT_BIT];
    scaled = i_prod;
    if (i_status_wr) begin
      st_nxt.status = i_status_wdata;
    end
    if (i_mask_wr) begin
      st_nxt.mask = i_mask_wdata[15:0]; // RULE13
    end
    st_nxt.mask_rd = {mac_round_pkg::MASK_UPPER, st_nxt.mask}; // RULE14
    st_nxt.prod_valid = i_prod_valid;
    if (frac) begin
      // scale factor not consulted here
      if (i_prod_long && round_sel) begin // RULE12
        st_nxt.prod = prif.res[39:0]; // RULE5 RULE6 RULE7 RULE17 RULE8
      end else begin
        st_nxt.prod = i_prod[63:mac_round_pkg::PROD_KEEP_LSB]; // RULE5
      end
    end else begin
      case (i_prod_sf)
        mac_round_pkg::SF_LEFT: scaled = i_prod << 1;
        mac_round_pkg::SF_RIGHT: scaled = i_prod >> 1;
        default: scaled = i_prod;
      endcase
      st_nxt.prod = scaled[39:0];
    end
    st_nxt.store_valid = i_store_valid;
    case (mode)
      // integer modes pass the accumulator untouched, round bit ignored
      mac_round_pkg::MODE_SIGNED_INT: st_nxt.store = i_acc[31:0]; // RULE1 RULE9
      mac_round_pkg::MODE_UNSIGNED_INT: st_nxt.store = i_acc[31:0]; // RULE1
      mac_round_pkg::MODE_FRAC_TRUNC: st_nxt.store = i_acc[39:8]; // RULE2
      mac_round_pkg::MODE_FRAC_ROUND32: st_nxt.store = srif.res[31:0]; // RULE2 RULE4
      mac_round_pkg::MODE_FRAC_R16_TRUNC,
      mac_round_pkg::MODE_FRAC_R16_ROUND: begin
        // sign-extended; a rounding carry past bit 15 wraps
        st_nxt.store = {{16{srif.res[15]}}, srif.res[15:0]}; // RULE3
      end
      default: st_nxt.store = i_acc[31:0];
    endcase
    st_nxt.mul_valid = i_mul_valid;
    st_nxt.mul = i_mul_signed ? smul : umul; // RULE11
    st_nxt.addr_valid = i_addr_valid;
    if (i_ext_word[mac_round_pkg::MASK_EXT_BIT]) begin // RULE16
      st_nxt.addr = i_addr & {mac_round_pkg::MASK_UPPER, st_r.mask}; // RULE15
    end else begin
      st_nxt.addr = i_addr;
    end
    if (!i_rst_n) begin
      st_nxt = '0;
      st_nxt.status = mac_round_pkg::STATUS_RESET;
      st_nxt.mask = mac_round_pkg::MASK_RESET;
      st_nxt.mask_rd = {mac_round_pkg::MASK_UPPER, mac_round_pkg::MASK_RESET};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    st_r <= st_nxt;
  end

  assign o_status_rdata = st_r.status;
  assign o_mask_rdata = st_r.mask_rd;
  assign o_prod_valid = st_r.prod_valid;
  assign o_prod = st_r.prod;
  assign o_store_valid = st_r.store_valid;
  assign o_store_data = st_r.store;
  assign o_mul_valid = st_r.mul_valid;
  assign o_mul_result = st_r.mul;
  assign o_addr_valid = st_r.addr_valid;
  assign o_addr = st_r.addr;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  int_store_raw_a: assert property ( // RULE1
    (i_store_valid && !frac) |=> (o_store_data == $past(i_acc[31:0])))
    else $error("integer store not raw");

  frac_trunc_store_a: assert property ( // RULE2
    (i_store_valid && mode == mac_round_pkg::MODE_FRAC_TRUNC) |=>
    (o_store_valid && o_store_data == $past(i_acc[39:8])))
    else $error("fractional truncating store wrong");

  r16_sign_ext_a: assert property ( // RULE3
    (i_store_valid && frac && st_r.status[mac_round_pkg::SU_BIT]) |=>
    (o_store_data[31:16] == {16{o_store_data[15]}}))
    else $error("16-bit store not sign-extended");

  r32_tie_even_a: assert property ( // RULE4
    (i_store_valid && mode == mac_round_pkg::MODE_FRAC_ROUND32 && i_acc[7:0] == 8'h80) |=>
    (o_store_data[0] == 1'b0))
    else $error("32-bit store tie not even");

  prod_trunc_a: assert property ( // RULE5
    (i_prod_valid && frac && !round_sel) |=>
    (o_prod == $past(i_prod[63:24])))
    else $error("product not truncated");

  below_half_a: assert property ( // RULE6
    (i_prod_valid && frac && round_sel && i_prod_long && i_prod[23:0] < mac_round_pkg::PROD_HALF)
    |=> (o_prod == $past(i_prod[63:24])))
    else $error("below half changed result");

  above_half_a: assert property ( // RULE6
    (i_prod_valid && frac && round_sel && i_prod_long && i_prod[23:0] > mac_round_pkg::PROD_HALF)
    |=> (o_prod == $past(i_prod[63:24]) + 40'h1))
    else $error("above half not incremented");

  tie_even_a: assert property ( // RULE17
    (i_prod_valid && frac && round_sel && i_prod_long && i_prod[23:0] == mac_round_pkg::PROD_HALF)
    |=> (o_prod[0] == 1'b0 && o_prod - $past(i_prod[63:24]) <= 40'h1))
    else $error("product tie not even");

  short_no_round_a: assert property ( // RULE8
    (i_prod_valid && frac && !i_prod_long) |=> (o_prod == $past(i_prod[63:24])))
    else $error("short product rounded");

  mul_integer_a: assert property ( // RULE11
    (i_mul_valid && i_mul_signed) |=> (o_mul_valid &&
    $signed(o_mul_result) == $signed($past(i_mul_a)) * $signed($past(i_mul_b))))
    else $error("signed multiply wrong");

  mask_load_a: assert property ( // RULE13
    i_mask_wr |=> (o_mask_rdata[15:0] == $past(i_mask_wdata[15:0])))
    else $error("mask load wrong");

  mask_upper_a: assert property ( // RULE14
    o_mask_rdata[31:16] == mac_round_pkg::MASK_UPPER)
    else $error("mask upper half not ones");

  addr_mask_a: assert property ( // RULE15
    (i_addr_valid && i_ext_word[mac_round_pkg::MASK_EXT_BIT]) |=>
    (o_addr_valid && o_addr == ($past(i_addr) & {16'hFFFF, $past(st_r.mask)})))
    else $error("masked address wrong");

  addr_plain_a: assert property ( // RULE16
    (i_addr_valid && !i_ext_word[mac_round_pkg::MASK_EXT_BIT]) |=> (o_addr == $past(i_addr)))
    else $error("unmasked address altered");

endmodule

/* File: cpu_model.sv */
// cpu-side model: status and mask register traffic, state save and restore
`timescale 1ns/10ps
module cpu_model (
  input wire logic i_ref_clk,
  input wire logic [7:0] i_status_rd,
  input wire logic [31:0] i_mask_rd,
  output logic o_status_wr,
  output logic [7:0] o_status_wdata,
  output logic o_mask_wr,
  output logic [31:0] o_mask_wdata
);
  initial begin
    o_status_wr = 1'b0;
    o_status_wdata = 8'h00;
    o_mask_wr = 1'b0;
    o_mask_wdata = 32'h0000_0000;
  end

  // one-cycle write pulse, data held until the strobe drops
  task automatic wr_status(input logic [7:0] d);
    @(negedge i_ref_clk);
    o_status_wr = 1'b1;
    o_status_wdata = d;
    @(negedge i_ref_clk);
    o_status_wr = 1'b0;
    o_status_wdata = ~d;
  endtask

  task automatic wr_mask(input logic [31:0] d);
    @(negedge i_ref_clk);
    o_mask_wr = 1'b1;
    o_mask_wdata = d;
    @(negedge i_ref_clk);
    o_mask_wr = 1'b0;
    o_mask_wdata = ~d;
  endtask

  // status cleared first so every read and write is bit-exact
  task automatic save_restore();
    logic [7:0] s;
    logic [31:0] k;
    s = i_status_rd;
    wr_status(8'h00);
    k = i_mask_rd;
    // mask scrubbed meanwhile, so the restore really has to reload it
    wr_mask(~k);
    wr_status(8'h00);
    wr_mask(k);
    wr_status(s);
  endtask
endmodule

/* File: tb_top.sv */
// self-checking bench for the mac rounding and address mask unit
`timescale 1ns/10ps
module tb_top;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_status_wr, i_mask_wr;
  logic [7:0] i_status_wdata, o_status_rdata;
  logic [31:0] i_mask_wdata, o_mask_rdata;
  logic i_prod_valid = 0, i_prod_long = 0, i_store_valid = 0, i_mul_valid = 0;
  logic i_mul_signed = 0, i_addr_valid = 0;
  logic [1:0] i_prod_sf = '0;
  logic [63:0] i_prod = '0;
  logic [47:0] i_acc = '0;
  logic [15:0] i_mul_a = '0, i_mul_b = '0, i_ext_word = '0;
  logic [31:0] i_addr = '0;
  logic o_prod_valid, o_store_valid, o_mul_valid, o_addr_valid;
  logic [39:0] o_prod;
  logic [31:0] o_store_data, o_mul_result, o_addr;
  logic [63:0] qp[$], qs[$], qm[$], qa[$];
  logic [7:0] st;
  logic [15:0] mk;
  int fails = 0;
  int compares = 0;

  initial forever #12.5 i_ref_clk = ~i_ref_clk;

  mac_round_unit dut (.i_ref_clk, .i_rst_n, .i_status_wr, .i_status_wdata, .i_mask_wr,
    .i_mask_wdata, .i_prod_valid, .i_prod_long, .i_prod_sf, .i_prod, .i_store_valid, .i_acc,
    .i_mul_valid, .i_mul_signed, .i_mul_a, .i_mul_b, .i_addr_valid, .i_addr, .i_ext_word,
    .o_status_rdata, .o_mask_rdata, .o_prod_valid, .o_prod, .o_store_valid, .o_store_data,
    .o_mul_valid, .o_mul_result, .o_addr_valid, .o_addr);

  cpu_model cpu (.i_ref_clk, .i_status_rd(o_status_rdata), .i_mask_rd(o_mask_rdata),
    .o_status_wr(i_status_wr), .o_status_wdata(i_status_wdata), .o_mask_wr(i_mask_wr),
    .o_mask_wdata(i_mask_wdata));

  task automatic check(input string nm, input logic [63:0] exp, input logic [63:0] seen);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // convergent rounding reference: drop d bits, ties go to even
  function automatic logic [63:0] rne(input logic [63:0] x, input int d);
    logic [63:0] up, rem, half;
    up = x >> d;
    rem = x & ((64'h1 << d) - 64'h1);
    half = 64'h1 << (d - 1);
    if (rem > half || (rem == half && up[0])) up = up + 64'h1;
    return up;
  endfunction

  // remainder near the half point, so ties and near-ties are hit often
  function automatic logic [63:0] near_half(input int w, input int k);
    return (64'h1 << (w - 1)) + 64'(k == 1) - 64'(k == 2);
  endfunction

  task automatic op();
    logic [63:0] e, h;
    int k;
    @(negedge i_ref_clk);
    {i_prod_valid, i_store_valid, i_mul_valid, i_addr_valid} = 4'($urandom);
    {i_prod_long, i_mul_signed, i_prod_sf} = 4'($urandom);
    i_prod = {$urandom, $urandom};
    i_acc = 48'({$urandom, $urandom});
    {i_mul_a, i_mul_b} = $urandom;
    i_addr = $urandom;
    i_ext_word = 16'($urandom);
    k = $urandom % 4;
    if (k != 3) begin
      h = near_half(24, k);
      i_prod[23:0] = h[23:0];
      h = near_half(st[6] ? 24 : 8, k);
      if (st[6]) i_acc[23:0] = h[23:0];
      else i_acc[7:0] = h[7:0];
    end
    if (st[5]) e = (i_prod_long && st[4]) ? rne(i_prod, 24) : i_prod >> 24;
    else e = (i_prod_sf == 2'h1) ? i_prod << 1 : (i_prod_sf == 2'h3) ? i_prod >> 1 : i_prod;
    if (i_prod_valid) qp.push_back({24'h0, e[39:0]});
    if (!st[5]) e = i_acc[31:0];
    else if (st[6]) begin
      e = rne(64'(i_acc), 24);
      e = {{48{e[15]}}, e[15:0]};
    end else e = st[4] ? rne(64'(i_acc), 8) : 64'(i_acc) >> 8;
    if (i_store_valid) qs.push_back({32'h0, e[31:0]});
    if (i_mul_signed) e[31:0] = $signed(i_mul_a) * $signed(i_mul_b);
    else e[31:0] = i_mul_a * i_mul_b;
    if (i_mul_valid) qm.push_back({32'h0, e[31:0]});
    e[31:0] = i_ext_word[5] ? i_addr & {16'hFFFF, mk} : i_addr;
    if (i_addr_valid) qa.push_back({32'h0, e[31:0]});
  endtask

  always begin
    @(posedge i_ref_clk);
    #1;
    if (o_prod_valid === 1'b1) check("prod", qp.size() ? qp.pop_front() : 'x, o_prod);
    if (o_store_valid === 1'b1) begin
      check("store", qs.size() ? qs.pop_front() : 'x, o_store_data);
    end
    if (o_mul_valid === 1'b1) begin
      check("mul", qm.size() ? qm.pop_front() : 'x, o_mul_result);
    end
    if (o_addr_valid === 1'b1) check("addr", qa.size() ? qa.pop_front() : 'x, o_addr);
  end

  initial begin
    repeat (3000) @(posedge i_ref_clk);
    fails++;
    end_sim();
  end

  initial begin
    logic [31:0] w;
    void'($urandom(32'hF3FC2133));
    st = 8'h00;
    repeat (16) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    check("mask reset", 32'hFFFF0000, o_mask_rdata);
    for (int i = 0; i < 6; i++) begin
      w = $urandom;
      cpu.wr_mask(w);
      mk = w[15:0];
      check("mask", {16'hFFFF, w[15:0]}, o_mask_rdata);
    end
    $display("mask test done");
    // all eight control combinations, including the ignored round bit
    for (int m = 0; m < 8; m++) begin
      st = {1'b0, 3'(m), 4'($urandom)};
      cpu.wr_status(st);
      check("status", st, o_status_rdata);
      repeat (40) op();
      @(negedge i_ref_clk);
      {i_prod_valid, i_store_valid, i_mul_valid, i_addr_valid} = 4'h0;
      $display("mode test %0d done", m);
    end
    cpu.save_restore();
    check("status restored", st, o_status_rdata);
    check("mask restored", {16'hFFFF, mk}, o_mask_rdata);
    $display("save restore test done");
    // with the status cleared every store must come back bit-exact
    st = 8'h00;
    cpu.wr_status(st);
    repeat (8) op();
    @(negedge i_ref_clk);
    {i_prod_valid, i_store_valid, i_mul_valid, i_addr_valid} = 4'h0;
    $display("bit exact test done");
    repeat (3) @(negedge i_ref_clk);
    check("queues drained", 64'h0,
      64'(qp.size() + qs.size() + qm.size() + qa.size()));
    end_sim();
  end
endmodule
